// ===== include/caf_params.svh
// Constants for the acceptance filter decoder
`ifndef CAF_PARAMS_SVH
`define CAF_PARAMS_SVH
`define CAF_STD_MAX        8'h80
`define CAF_EXT_MAX        8'h40
`define CAF_ACT_DISABLE    3'h0
`define CAF_ACT_FIFO0      3'h1
`define CAF_ACT_FIFO1      3'h2
`define CAF_ACT_REJECT     3'h3
`define CAF_ACT_PRIO       3'h4
`define CAF_ACT_PRIO_F0    3'h5
`define CAF_ACT_PRIO_F1    3'h6
`define CAF_ACT_BUFFER     3'h7
`define CAF_FT_RANGE       2'h0
`define CAF_FT_DUAL        2'h1
`define CAF_FT_CLASSIC     2'h2
`define CAF_FT_RANGE_NOMSK 2'h3
`define CAF_DST_RXBUF      2'h0
`define CAF_STD_FT_HI      31
`define CAF_STD_FT_LO      30
`define CAF_STD_ACT_HI     29
`define CAF_STD_ACT_LO     27
`define CAF_STD_ID1_HI     26
`define CAF_STD_ID1_LO     16
`define CAF_STD_SYNC_BIT   15
`define CAF_EXT_ACT_HI     31
`define CAF_EXT_ACT_LO     29
`define CAF_EXT_FT_HI      31
`define CAF_EXT_FT_LO      30
`define CAF_EXT_SYNC_BIT   29
`define CAF_DST_HI         10
`define CAF_DST_LO         9
`define CAF_FE_HI          8
`define CAF_FE_LO          6
`define CAF_OFS_HI         5
`define CAF_OFS_LO         0
`endif

// ===== include/caf_pkg.sv
// Types for the acceptance filter decoder
package caf_pkg;
    typedef struct packed {
        logic        ext;      // 1 = 29-bit identifier
        logic [28:0] id;       // Standard id in bits 10:0
    } caf_frame_t;

    typedef struct packed {
        logic        accept;
        logic        reject;
        logic        fifo0;
        logic        fifo1;
        logic        rxbuf;
        logic [1:0]  dbg_sel;  // 01 A, 10 B, 11 C, 00 none
        logic        prio;
        logic        no_match;
        logic [6:0]  index;
        logic [15:0] buf_addr;
    } caf_result_t;
endpackage

// ===== rtl/caf_elem_match.sv
// Single filter element comparator: decodes one element and tests one id
`timescale 1ns/1ps
`include "caf_params.svh"
module caf_elem_match
    import caf_pkg::*;
(
    input  wire logic        i_ext,
    input  wire logic [31:0] i_word0,
    input  wire logic [31:0] i_word1,
    input  wire logic [28:0] i_id,
    input  wire logic [28:0] i_ext_mask,
    output logic             o_match,
    output logic [2:0]       o_action,
    output logic             o_sync,
    output logic [28:0]      o_second_id
);
    logic [1:0]  ftype;
    logic [28:0] id1;
    logic [28:0] id2;
    logic [28:0] mid;
    logic        cmp;

    // Field split per format; standard ids are zero-extended to 29 bits
    always_comb begin
        if (i_ext) begin
            o_action = i_word0[`CAF_EXT_ACT_HI:`CAF_EXT_ACT_LO];          // [R15]
            ftype    = i_word1[`CAF_EXT_FT_HI:`CAF_EXT_FT_LO];
            id1      = i_word0[28:0];
            id2      = i_word1[28:0];
            o_sync   = i_word1[`CAF_EXT_SYNC_BIT];                          // [R12]
        end else begin
            o_action = i_word0[`CAF_STD_ACT_HI:`CAF_STD_ACT_LO];          // [R03]
            ftype    = i_word0[`CAF_STD_FT_HI:`CAF_STD_FT_LO];
            id1      = {18'h00000, i_word0[`CAF_STD_ID1_HI:`CAF_STD_ID1_LO]};
            id2      = {18'h00000, i_word0[10:0]};                          // [R08]
            o_sync   = i_word0[`CAF_STD_SYNC_BIT];
        end
        o_second_id = id2;
    end

    // Global mask only for extended frames, dropped in unmasked-range type
    always_comb begin
        mid = i_ext ? (i_id & i_ext_mask) : i_id;
        cmp = 1'b0;
        if (o_action == `CAF_ACT_BUFFER) begin
            cmp = (mid == id1);                                 // [R06] [R07] [R17]
        end else begin
            case (ftype)
                `CAF_FT_RANGE:   cmp = (mid >= id1) && (mid <= id2);            // [R22]
                `CAF_FT_DUAL:    cmp = (mid == id1) || (mid == id2);
                `CAF_FT_CLASSIC: cmp = ((mid ^ id1) & id2) == 29'h00000000;
                default: begin
                    // Standard type 11 disables; extended 11 is raw range
                    cmp = i_ext && (i_id >= id1) && (i_id <= id2);      // [R16] [R19]
                end
            endcase
        end
        o_match = (o_action != `CAF_ACT_DISABLE) && cmp;                // [R03]
    end
endmodule

// ===== rtl/caf_filter.sv
// Acceptance filter: walks standard or extended list in message memory
`timescale 1ns/1ps
`include "caf_params.svh"
// Notes on behaviour
// [R01] Standard elements filter only 11-bit frames, extended only 29-bit frames.
// [R02] Elements walk in order; stop at first enabled match or list end.
// [R03] Action 000 off, 001 FIFO0, 010 FIFO1, 011 reject.
// [R04] 100 priority only, 101 priority plus FIFO0, 110 priority plus FIFO1.
// [R05] Priority match sets flag, interrupt if enabled, updates priority status.
// [R06] Action 111 goes to dedicated buffer or debug path; filter type ignored.
// [R07] Standard buffer/debug match compares first id exactly, unmasked.
// [R08] Actions 001..110 use standard second id as second operand.
// [R09] Under 111 second id bits 10:9 pick buffer or debug A, B, C.
// [R10] Under 111 second id bits 8:6 enable one-cycle filter event pulses.
// [R11] Under 111 buffer offset bits 5:0 add to buffer start address.
// [R12] Sync flag pulses sync-capture for one cycle when timestamp unit enabled.
// [R13] Sync pulse fires regardless of whether frame is finally stored.
// [R14] Extended list holds 64 two-word elements at start plus twice index.
// [R15] Extended action field bits 31:29 uses same eight codes.
// [R16] Extended types: range, dual, classic mask, range without global mask.
// [R17] Extended buffer/debug match is exact after global extended mask.
// [R18] Extended 111 second id bits mirror standard destination, event, offset.
// [R19] Standard types: range, dual, classic mask, 11 disables element.
// [R20] Standard list holds 128 one-word elements at start plus index.
// [R21] No match hands frame to global non-matching handling.
// [R22] Ranges inclusive at both ends, full identifier width compared.
module caf_filter
    import caf_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_frame_valid,
    input  wire caf_frame_t  i_frame,
    input  wire logic [7:0]  i_std_list_size,
    input  wire logic [6:0]  i_ext_list_size,
    input  wire logic [15:0] i_std_list_start_addr,
    input  wire logic [15:0] i_ext_list_start_addr,
    input  wire logic [15:0] i_rx_buffer_start_addr,
    input  wire logic [28:0] i_global_ext_id_mask,
    input  wire logic        i_use_ext_timestamp_unit,
    input  wire logic        i_high_prio_irq_enable,
    input  wire logic        i_high_prio_flag_clear,
    input  wire logic        i_mem_rvalid,
    input  wire logic [31:0] i_mem_rdata,
    output logic             o_busy,
    output logic             o_mem_req,
    output logic [15:0]      o_mem_addr,
    output logic             o_result_valid,
    output caf_result_t      o_result,
    output logic [2:0]       o_filter_event_pulses,
    output logic             o_sync_capture,
    output logic             o_high_prio_match_irq_flag,
    output logic             o_high_prio_irq,
    output logic [15:0]      o_prio_match_status
);
    typedef enum logic [2:0] {
        CAF_IDLE,
        CAF_FETCH0,
        CAF_WAIT0,
        CAF_FETCH1,
        CAF_WAIT1,
        CAF_EVAL,
        CAF_DONE
    } caf_state_t;

    caf_state_t  state_q, state_d;
    caf_frame_t  frame_q, frame_d;
    logic [6:0]  idx_q, idx_d;
    logic [31:0] w0_q, w0_d;
    logic [31:0] w1_q, w1_d;
    caf_result_t res_q, res_d;
    logic        rvalid_q, rvalid_d;
    logic [2:0]  fe_q, fe_d;
    logic        sync_q, sync_d;
    logic        hpm_q, hpm_d;
    logic [15:0] prio_match_status_q, prio_match_status_d;
    logic [15:0] addr_q, addr_d;

    logic        el_match;
    logic [2:0]  el_action;
    logic        el_sync;
    logic [28:0] el_id2;
    logic [7:0]  list_len;
    logic        last_elem;
    logic        prio_hit;

    // Both formats share one comparator; standard elements read word 0 only
    caf_elem_match u_match (
        .i_ext       (frame_q.ext),
        .i_word0     (w0_q),
        .i_word1     (w1_q),
        .i_id        (frame_q.id),
        .i_ext_mask  (i_global_ext_id_mask),
        .o_match     (el_match),
        .o_action    (el_action),
        .o_sync      (el_sync),
        .o_second_id (el_id2)
    );

    // Frame format picks the list, so each list sees only its own ids
    assign list_len  = frame_q.ext ? {1'b0, i_ext_list_size} : i_std_list_size;  // [R01]
    assign last_elem = ({1'b0, idx_q} + 8'h01) >= list_len;
    assign prio_hit  = (el_action == `CAF_ACT_PRIO) || (el_action == `CAF_ACT_PRIO_F0) ||
                       (el_action == `CAF_ACT_PRIO_F1);

    // Walk state, element fetch and verdict
    always_comb begin
        state_d  = state_q;
        frame_d  = frame_q;
        idx_d    = idx_q;
        w0_d     = w0_q;
        w1_d     = w1_q;
        res_d    = res_q;
        rvalid_d = 1'b0;
        fe_d     = 3'h0;
        sync_d   = 1'b0;
        hpm_d    = hpm_q;
        prio_match_status_d   = prio_match_status_q;
        addr_d   = addr_q;
        case (state_q)
            CAF_IDLE: begin
                if (i_frame_valid) begin
                    frame_d = i_frame;
                    idx_d   = 7'h00;
                    w1_d    = 32'h00000000;
                    state_d = CAF_FETCH0;
                end
            end
            CAF_FETCH0: begin
                if (({1'b0, idx_q}) >= list_len) begin
                    state_d = CAF_DONE;
                    res_d   = '0;
                    res_d.no_match = 1'b1;                              // [R21]
                    rvalid_d = 1'b1;
                end else begin
                    // Extended slot is two words, standard slot one
                    if (frame_q.ext) begin
                        addr_d = i_ext_list_start_addr + {8'h00, idx_q, 1'b0};  // [R14]
                    end else begin
                        addr_d = i_std_list_start_addr + {9'h000, idx_q};       // [R20]
                    end
                    state_d = CAF_WAIT0;
                end
            end
            CAF_WAIT0: begin
                if (i_mem_rvalid) begin
                    w0_d    = i_mem_rdata;
                    addr_d  = addr_q + 16'h0001;
                    state_d = frame_q.ext ? CAF_FETCH1 : CAF_EVAL;
                end
            end
            CAF_FETCH1: begin
                state_d = CAF_WAIT1;
            end
            CAF_WAIT1: begin
                if (i_mem_rvalid) begin
                    w1_d    = i_mem_rdata;
                    state_d = CAF_EVAL;
                end
            end
            CAF_EVAL: begin
                if (el_match) begin                                     // [R02]
                    res_d          = '0;
                    res_d.index    = idx_q;
                    res_d.reject   = (el_action == `CAF_ACT_REJECT);
                    res_d.fifo0    = (el_action == `CAF_ACT_FIFO0) ||
                                     (el_action == `CAF_ACT_PRIO_F0);       // [R04]
                    res_d.fifo1    = (el_action == `CAF_ACT_FIFO1) ||
                                     (el_action == `CAF_ACT_PRIO_F1);
                    res_d.prio     = prio_hit;
                    if (el_action == `CAF_ACT_BUFFER) begin
                        // Destination and events come from second id low bits
                        res_d.rxbuf   = (el_id2[`CAF_DST_HI:`CAF_DST_LO] ==
                                         `CAF_DST_RXBUF);                  // [R09] [R18]
                        res_d.dbg_sel = el_id2[`CAF_DST_HI:`CAF_DST_LO];
                        res_d.buf_addr = i_rx_buffer_start_addr +
                            {10'h000, el_id2[`CAF_OFS_HI:`CAF_OFS_LO]};   // [R11]
                        fe_d = el_id2[`CAF_FE_HI:`CAF_FE_LO];               // [R10]
                    end
                    res_d.accept = res_d.fifo0 || res_d.fifo1 ||
                                   (el_action == `CAF_ACT_BUFFER);
                    // Pulse even if storage later fails on a full FIFO
                    sync_d = el_sync && i_use_ext_timestamp_unit;       // [R12] [R13]
                    if (prio_hit) begin
                        hpm_d  = 1'b1;                                  // [R05]
                        prio_match_status_d = {frame_q.ext, 1'b0, el_action[1:0] == 2'h0 ? 2'h0 :
                                  el_action[1:0], 5'h00, idx_q};
                    end
                    rvalid_d = 1'b1;
                    state_d  = CAF_DONE;
                end else if (last_elem) begin
                    res_d          = '0;
                    res_d.no_match = 1'b1;                              // [R21]
                    rvalid_d       = 1'b1;
                    state_d        = CAF_DONE;
                end else begin
                    idx_d   = idx_q + 7'h01;
                    state_d = CAF_FETCH0;
                end
            end
            CAF_DONE: begin
                state_d = CAF_IDLE;
            end
            default: begin
                state_d = CAF_IDLE;
            end
        endcase
        // Clear loses to a new priority match in the same cycle
        if (i_high_prio_flag_clear && !(state_q == CAF_EVAL && el_match && prio_hit)) begin
            hpm_d = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q  <= CAF_IDLE;
            frame_q  <= '0;
            idx_q    <= 7'h00;
            w0_q     <= 32'h00000000;
            w1_q     <= 32'h00000000;
            res_q    <= '0;
            rvalid_q <= 1'b0;
            fe_q     <= 3'h0;
            sync_q   <= 1'b0;
            hpm_q    <= 1'b0;
            prio_match_status_q   <= 16'h0000;
            addr_q   <= 16'h0000;
        end else begin
            state_q  <= state_d;
            frame_q  <= frame_d;
            idx_q    <= idx_d;
            w0_q     <= w0_d;
            w1_q     <= w1_d;
            res_q    <= res_d;
            rvalid_q <= rvalid_d;
            fe_q     <= fe_d;
            sync_q   <= sync_d;
            hpm_q    <= hpm_d;
            prio_match_status_q   <= prio_match_status_d;
            addr_q   <= addr_d;
        end
    end

    // Outputs; memory request is a level while waiting for read data
    assign o_busy                     = (state_q != CAF_IDLE);
    assign o_mem_req                  = (state_q == CAF_WAIT0) || (state_q == CAF_WAIT1);
    assign o_mem_addr                 = addr_q;
    assign o_result_valid             = rvalid_q;
    assign o_result                   = res_q;
    assign o_filter_event_pulses      = fe_q;
    assign o_sync_capture             = sync_q;
    assign o_high_prio_match_irq_flag = hpm_q;
    assign o_high_prio_irq            = hpm_q && i_high_prio_irq_enable;    // [R05]
    assign o_prio_match_status        = prio_match_status_q;
endmodule

// ===== tb/caf_filter_chk.sv
// Port-level property checker for the acceptance filter
`timescale 1ns/1ps
module caf_filter_chk
    import caf_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_use_ext_timestamp_unit,
    input wire logic        i_high_prio_irq_enable,
    input wire logic        i_high_prio_flag_clear,
    input wire logic        o_result_valid,
    input wire caf_result_t o_result,
    input wire logic [2:0]  o_filter_event_pulses,
    input wire logic        o_sync_capture,
    input wire logic        o_high_prio_match_irq_flag,
    input wire logic        o_high_prio_irq,
    input wire logic [15:0] o_prio_match_status
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // Event and sync pulses ride with a matching result and last one cycle
    a_event_single: assert property (
        |o_filter_event_pulses |=> o_filter_event_pulses == 3'h0) else $error("event too long");
    a_event_cause: assert property (
        |o_filter_event_pulses |-> o_result_valid && (o_result.rxbuf || o_result.dbg_sel != 2'h0))
        else $error("event without buffer match");
    a_sync_unit: assert property (
        o_sync_capture |-> o_result_valid && !o_result.no_match && $past(i_use_ext_timestamp_unit))
        else $error("sync pulse without cause");
    a_sync_single: assert property (
        o_sync_capture |=> !o_sync_capture) else $error("sync pulse too long");
    // Priority match side effects
    a_prio_flag: assert property (
        o_result_valid && o_result.prio |-> o_high_prio_match_irq_flag) else $error("flag not set");
    a_prio_status: assert property (
        o_result_valid && o_result.prio |-> ##[0:1] o_prio_match_status[6:0] == o_result.index)
        else $error("priority status index wrong");
    a_irq_gate: assert property (
        o_high_prio_irq == (o_high_prio_match_irq_flag && i_high_prio_irq_enable))
        else $error("interrupt not gated by enable");
    a_flag_sticky: assert property (
        o_high_prio_match_irq_flag && !i_high_prio_flag_clear |=> o_high_prio_match_irq_flag)
        else $error("flag dropped without clear");
    // Reject results carry no storage; no-match results carry index 0 and no reject
    a_reject_clean: assert property (
        o_result_valid && o_result.reject |-> !(o_result.fifo0 || o_result.fifo1 || o_result.rxbuf
        || o_result.prio) && o_result.dbg_sel == 2'h0) else $error("reject also stores");
    a_nomatch_clean: assert property (
        o_result_valid && o_result.no_match |-> o_result.index == 7'h00 && !o_result.reject)
        else $error("no match result not clean");

    c_prio: cover property (o_result_valid && o_result.prio);
    c_event: cover property (|o_filter_event_pulses);
    c_sync: cover property (o_sync_capture);
endmodule

bind caf_filter caf_filter_chk u_chk (.i_clk, .i_rstn, .i_use_ext_timestamp_unit,
    .i_high_prio_irq_enable, .i_high_prio_flag_clear, .o_result_valid, .o_result,
    .o_filter_event_pulses, .o_sync_capture, .o_high_prio_match_irq_flag, .o_high_prio_irq,
    .o_prio_match_status);

// ===== tb/caf_mem_model.sv
// Message memory model answering the filter's word fetches
`timescale 1ns/1ps
module caf_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    input  wire logic [1:0]  i_lat,
    output logic             o_rvalid,
    output logic [31:0]      o_rdata
);
    logic [31:0] mem [0:255];
    logic [1:0]  wait_q;

    // One-cycle answer after the chosen wait; idle data toggles so stale words never pass
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rvalid <= 1'b0;
            wait_q   <= 2'h0;
            o_rdata  <= 32'hA5A5A5A5;
        end else if (o_rvalid) begin
            o_rvalid <= 1'b0;
            wait_q   <= 2'h0;
            o_rdata  <= ~o_rdata;
        end else if (i_req && wait_q == i_lat) begin
            o_rvalid <= 1'b1;
            o_rdata  <= mem[i_addr[7:0]];
        end else begin
            wait_q   <= i_req ? wait_q + 2'h1 : 2'h0;
            o_rdata  <= ~o_rdata;
        end
    end
endmodule

// ===== tb/tb_caf_filter.sv
// Self-checking bench for the acceptance filter decoder
`timescale 1ns/1ps
module tb_caf_filter
    import caf_pkg::*;
;
    logic        i_clk, i_rstn, i_frame_valid, i_use_ext_timestamp_unit, i_high_prio_irq_enable;
    logic        i_high_prio_flag_clear, i_mem_rvalid, o_busy, o_mem_req, o_result_valid;
    logic        o_sync_capture, o_high_prio_match_irq_flag, o_high_prio_irq, sy;
    logic [7:0]  i_std_list_size;
    logic [6:0]  i_ext_list_size;
    logic [1:0]  lat;
    logic [28:0] i_global_ext_id_mask;
    logic [31:0] i_mem_rdata;
    logic [15:0] o_mem_addr, o_prio_match_status;
    logic [2:0]  o_filter_event_pulses;
    caf_frame_t  i_frame;
    caf_result_t o_result;
    int          bad_count, n_compared;
    // Result flags per action code: reject fifo0 fifo1 rxbuf dbg[1:0] prio nomatch
    logic [7:0]  fl [8] = '{8'h20, 8'h40, 8'h20, 8'h80, 8'h02, 8'h42, 8'h22, 8'h10};

    // List bases stay fixed; the memory model is laid out around them
    caf_filter dut (.i_clk, .i_rstn, .i_frame_valid, .i_frame, .i_std_list_size,
        .i_ext_list_size, .i_std_list_start_addr(16'h0010), .i_ext_list_start_addr(16'h0080),
        .i_rx_buffer_start_addr(16'h0200), .i_global_ext_id_mask, .i_use_ext_timestamp_unit,
        .i_high_prio_irq_enable, .i_high_prio_flag_clear, .i_mem_rvalid, .i_mem_rdata, .o_busy,
        .o_mem_req, .o_mem_addr, .o_result_valid, .o_result, .o_filter_event_pulses,
        .o_sync_capture, .o_high_prio_match_irq_flag, .o_high_prio_irq, .o_prio_match_status);
    caf_mem_model m (.i_clk, .i_rstn, .i_req(o_mem_req), .i_addr(o_mem_addr), .i_lat(lat),
        .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata));

    // 50 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [31:0] sw(input logic [1:0] t, input logic [2:0] a,
                                       input logic [10:0] i1, input logic s, input logic [10:0] i2);
        sw = {t, a, i1, s, 4'h0, i2};
    endfunction

    task automatic xel(input int i, input logic [1:0] t, input logic [2:0] a,
                       input logic [28:0] d1, input logic s, input logic [28:0] d2);
        m.mem[8'h80 + 2 * i] = {a, d1};
        m.mem[8'h81 + 2 * i] = {t, s, d2};
    endtask

    // One frame offered, result and its pulses compared in the result cycle
    task automatic frm(input logic x, input logic [28:0] id, input logic [14:0] e,
                       input logic [2:0] fe, input logic s);
        int k;
        @(negedge i_clk);
        i_frame = {x, id};
        i_frame_valid = 1'b1;
        @(negedge i_clk);
        i_frame_valid = 1'b0;
        chk("busy", 32'h1, {31'h0, o_busy});
        k = 0;
        while (o_result_valid !== 1'b1 && k < 500) begin
            @(negedge i_clk);
            k++;
        end
        if (k == 500) begin
            bad_count++;
            $display("ERROR result_valid expected 1 seen 0");
            results();
        end
        chk("result", e, {o_result.reject, o_result.fifo0, o_result.fifo1, o_result.rxbuf,
            o_result.dbg_sel, o_result.prio, o_result.no_match, o_result.index});
        chk("filter events", fe, o_filter_event_pulses);
        chk("sync capture", s, o_sync_capture);
    endtask

    task automatic prio_chk(input logic x, input logic [1:0] a);
        chk("prio flag", 1'b1, o_high_prio_match_irq_flag);
        chk("prio irq", i_high_prio_irq_enable, o_high_prio_irq);
        chk("prio status", {x, 1'b0, a, 12'h000}, o_prio_match_status);
        i_high_prio_flag_clear = 1'b1;
        @(negedge i_clk);
        i_high_prio_flag_clear = 1'b0;
        chk("cleared flag", 1'b0, o_high_prio_match_irq_flag);
    endtask

    // Main sequence
    initial begin
        {i_rstn, i_frame_valid, i_high_prio_flag_clear, i_high_prio_irq_enable} = 4'h0;
        {i_use_ext_timestamp_unit, i_frame, lat, i_std_list_size, i_ext_list_size} = '0;
        i_global_ext_id_mask = 29'h1FFFFFFE;
        repeat (8) @(negedge i_clk);
        i_rstn = 1'b1;
        @(negedge i_clk);
        chk("idle result", 32'h0, o_result);
        chk("idle busy", 32'h0, {31'h0, o_busy});
        // Every action code on element 0; element 1 catches the disabled one
        i_use_ext_timestamp_unit = 1'b1;
        i_std_list_size = 8'h02;
        m.mem[8'h11] = sw(2'h1, 3'h2, 11'h123, 1'b1, 11'h7FF);
        for (int a = 0; a < 8; a++) begin
            sy = (a != 3 && a != 4);
            lat = a[1:0];
            i_high_prio_irq_enable = a[0];
            m.mem[8'h10] = sw((a == 7) ? 2'h3 : 2'h1, a[2:0], (a == 7) ? 11'h123 : 11'h000, sy,
                              (a == 7) ? 11'h145 : 11'h123);
            frm(1'b0, 29'h123, {fl[a], 6'h00, a == 0}, (a == 7) ? 3'h5 : 3'h0,
                sy | a == 0);
            if (a == 7) chk("buffer address", 16'h0205, o_result.buf_addr);
            if (a > 3 && a < 7) prio_chk(1'b0, a[1:0]);
        end
        $display("action code test done");
        // Standard filter types and bounds
        i_std_list_size = 8'h01;
        lat = 2'h0;
        m.mem[8'h10] = sw(2'h0, 3'h1, 11'h00A, 1'b0, 11'h014);
        frm(1'b0, 29'h00A, 15'h2000, 3'h0, 1'b0);
        frm(1'b0, 29'h014, 15'h2000, 3'h0, 1'b0);
        frm(1'b0, 29'h015, 15'h0080, 3'h0, 1'b0);
        m.mem[8'h10] = sw(2'h2, 3'h2, 11'h120, 1'b0, 11'h7F0);
        frm(1'b0, 29'h12F, 15'h1000, 3'h0, 1'b0);
        frm(1'b0, 29'h13F, 15'h0080, 3'h0, 1'b0);
        m.mem[8'h10] = sw(2'h3, 3'h1, 11'h12F, 1'b0, 11'h12F);
        frm(1'b0, 29'h12F, 15'h0080, 3'h0, 1'b0);
        m.mem[8'h10] = sw(2'h1, 3'h1, 11'h12F, 1'b0, 11'h12F);
        frm(1'b1, 29'h12F, 15'h0080, 3'h0, 1'b0);
        $display("standard type test done");
        // Extended list: masked range miss, then buffer action per destination
        i_ext_list_size = 7'h02;
        lat = 2'h2;
        xel(0, 2'h0, 3'h1, 29'h1000001, 1'b0, 29'h1000001);
        for (int d = 0; d < 4; d++) begin
            xel(1, 2'h1, 3'h7, 29'h1000000, d == 3, {18'h0, d[1:0], 3'h1, 6'h03});
            frm(1'b1, 29'h1000001, {(d == 0) ? 8'h10 : {4'h0, d[1:0], 2'h0}, 7'h01},
                3'h1, d == 3);
            if (d == 0) chk("buffer address", 16'h0203, o_result.buf_addr);
        end
        i_use_ext_timestamp_unit = 1'b0;
        frm(1'b1, 29'h1000001, 15'h0601, 3'h1, 1'b0);
        xel(0, 2'h3, 3'h1, 29'h1000001, 1'b0, 29'h1000001);
        frm(1'b1, 29'h1000001, 15'h2000, 3'h0, 1'b0);
        i_global_ext_id_mask = 29'h1FFFFFFF;
        xel(0, 2'h1, 3'h2, 29'h0000001, 1'b0, 29'h0ABCDEF);
        frm(1'b1, 29'h0ABCDEF, 15'h1000, 3'h0, 1'b0);
        xel(0, 2'h2, 3'h6, 29'h0ABCD00, 1'b0, 29'h1FFFFF00);
        i_high_prio_irq_enable = 1'b1;
        frm(1'b1, 29'h0ABCD55, 15'h1100, 3'h0, 1'b0);
        prio_chk(1'b1, 2'h2);
        $display("extended list test done");
        results();
    end
endmodule
